// File: rtl/lcg_pkg.sv
// Constants and types for the loop compensation gain configuration block.
// Assumes a single system clock; command codes arrive as byte values.
package lcg_pkg;

	// Command codes of the paged compensation registers
	localparam logic [7:0]  LCG_CMD_PROP  = 8'hdd;
	localparam logic [7:0]  LCG_CMD_INTEG = 8'hde;
	localparam logic [7:0]  LCG_CMD_DIFF  = 8'hdf;
	localparam logic [7:0]  LCG_CMD_CFB   = 8'he0;

	// Reset values
	localparam logic [31:0] LCG_RST_PROP  = 32'hd90907c4;
	localparam logic [31:0] LCG_RST_INTEG = 32'h000000a9;
	localparam logic [15:0] LCG_RST_DIFF  = 16'h0000;
	localparam logic [15:0] LCG_RST_CFB   = 16'h0560;

	// Writable bits of the derivative register, upper three read zero
	localparam logic [15:0] LCG_DIFF_WMASK = 16'h1fff;

	// Proportional register fields (LSB positions)
	localparam int LCG_P_COM_E = 0;
	localparam int LCG_P_COM_M = 4;
	localparam int LCG_P_FIR   = 8;
	localparam int LCG_P_O1_E  = 9;
	localparam int LCG_P_O1_M  = 13;
	localparam int LCG_P_O2_E  = 17;
	localparam int LCG_P_O2_M  = 21;
	localparam int LCG_P_O8_E  = 25;
	localparam int LCG_P_O8_M  = 28;

	// Integral register fields
	localparam int LCG_I_BASE = 0;
	localparam int LCG_I_MAX  = 4;
	localparam int LCG_I_DCM  = 8;
	localparam int LCG_I_DLY  = 12;

	// Derivative register fields
	localparam int LCG_D_EXP  = 0;
	localparam int LCG_D_MANT = 2;
	localparam int LCG_D_O1_E = 6;
	localparam int LCG_D_O1_M = 8;
	localparam int LCG_D_FIR  = 12;

	// Current feedback register fields
	localparam int LCG_C_GAIN = 0;
	localparam int LCG_C_HPF  = 8;

	// Bias of the proportional exponent and phase thresholds
	localparam logic signed [3:0] LCG_P_EXP_BIAS = 4'sd3;
	localparam int LCG_MANY_PHASES = 8;

	// Integral step unit: 16 loop clock periods
	localparam int LCG_LOOP_CLOCK_PERIOD_NS = 100;
	localparam int LCG_CLK_PERIOD_NS        = 100;
	localparam int LCG_UNIT_PERIODS         = 16;
	localparam int LCG_STEP_CLKS = LCG_UNIT_PERIODS *
		(LCG_LOOP_CLOCK_PERIOD_NS / LCG_CLK_PERIOD_NS);

	// Mantissa / exponent pair of one gain
	typedef struct packed {
		logic [3:0] mant;
		logic [2:0] expo;
	} lcg_gain_t;

	// One register access from the management bus engine
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  cmd;
		logic [7:0]  page;
		logic [31:0] wdata;
	} lcg_req_t;

	// Integral gain stepper states
	typedef enum logic [1:0] {
		LCG_I_RUN    = 2'b00,
		LCG_I_STEP   = 2'b01,
		LCG_I_SETTLE = 2'b10
	} lcg_istate_t;

	// True for the four compensation command codes
	function automatic logic lcg_mapped(input logic [7:0] cmd);
		return (cmd == LCG_CMD_PROP) || (cmd == LCG_CMD_INTEG) ||
			(cmd == LCG_CMD_DIFF) || (cmd == LCG_CMD_CFB);
	endfunction

endpackage

// File: rtl/lcg_gain_pick.sv
// Chooses the active gain pair from the common pair and phase overrides.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module lcg_gain_pick
	import lcg_pkg::*;
#(
	parameter int PHW = 5
) (
	input  wire logic [PHW-1:0] phases,
	input  wire lcg_gain_t      com,
	input  wire lcg_gain_t      ovr1,
	input  wire lcg_gain_t      ovr2,
	input  wire lcg_gain_t      ovr8,
	output lcg_gain_t           sel
);

	// An override is live unless both its fields are zero
	function automatic logic live(input lcg_gain_t g);
		return (g.mant != 4'h0) || (g.expo != 3'h0);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Selection by active phase count
	always_comb begin
		sel = com;
		if (phases == PHW'(1) && live(ovr1)) begin
			sel = ovr1;
		end else if (phases == PHW'(2) && live(ovr2)) begin
			sel = ovr2;
		end else if (phases > PHW'(LCG_MANY_PHASES) && live(ovr8)) begin
			sel = ovr8;
		end
	end

endmodule

// File: rtl/lcg_integ_step.sv
// Integral gain shift of one rail, stepped toward the DCM value.
// Assumes dcm and moving are synchronous to clk_sys.
`timescale 1ns/100ps
module lcg_integ_step
	import lcg_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [15:0] cfg,
	input  wire logic       dcm,
	input  wire logic       moving,
	output logic [3:0]      shift_reg,
	output logic            settled
);

	lcg_istate_t state_reg;
	lcg_istate_t state_next;
	logic [7:0]  wait_reg;
	logic [3:0]  dcm_sh;
	logic [7:0]  wait_len;
	logic        step_due;

	// Step wait is the delay field in units of 16 loop clocks
	assign dcm_sh   = cfg[LCG_I_DCM +: 4];
	assign wait_len = 8'(cfg[LCG_I_DLY +: 4] * LCG_STEP_CLKS);
	assign step_due = (wait_reg + 8'h01 >= wait_len);
	assign settled  = (state_reg == LCG_I_SETTLE);

	////////////////////////////////////////////////////////////////////
	// State choice
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LCG_I_RUN: begin
				if (dcm) begin
					state_next = LCG_I_STEP;
				end
			end
			LCG_I_STEP: begin
				if (!dcm) begin
					state_next = LCG_I_RUN;
				end else if (shift_reg == dcm_sh) begin
					state_next = LCG_I_SETTLE;
				end
			end
			LCG_I_SETTLE: begin
				if (!dcm) begin
					state_next = LCG_I_RUN;
				end else if (shift_reg != dcm_sh) begin
					state_next = LCG_I_STEP;
				end
			end
			default: state_next = LCG_I_RUN;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= LCG_I_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Step wait counter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 8'h00;
		end else if (state_reg != LCG_I_STEP || step_due) begin
			wait_reg <= 8'h00;
		end else begin
			wait_reg <= wait_reg + 8'h01;
		end
	end

	// Gain shift: base or max in CCM, one step at a time in DCM
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= LCG_RST_INTEG[LCG_I_BASE +: 4];
		end else if (state_reg == LCG_I_RUN) begin
			shift_reg <= moving ? cfg[LCG_I_MAX +: 4]
				: cfg[LCG_I_BASE +: 4];
		end else if (state_reg == LCG_I_STEP && step_due) begin
			if (shift_reg < dcm_sh) begin
				shift_reg <= shift_reg + 4'h1;
			end else if (shift_reg > dcm_sh) begin
				shift_reg <= shift_reg - 4'h1;
			end
		end
	end

	// A DCM step moves the shift by exactly one
	chk_i_step_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($past(state_reg) == LCG_I_STEP && $changed(shift_reg))
		|-> (shift_reg == $past(shift_reg) + 4'h1 ||
			shift_reg == $past(shift_reg) - 4'h1))
		else $error("integral shift moved more than one step");

	// Once settled with a steady target, the shift holds it
	chk_i_settle_hold: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		(settled && dcm && $stable(cfg)) |=>
		(shift_reg == $past(dcm_sh)))
		else $error("settled integral shift left the DCM value");

endmodule

// File: rtl/lcg_comp_cfg.sv
// Paged compensation gain registers and the gain selection they drive.
// Assumes the bus engine gives one access per request, page included.
// What this block does
// - Common P mantissa is bits 7:4 over eight
// - P exponent 2^(field-3); all-zero gives zero
// - One phase uses P override 16:13, 11:9
// - Two phases use P override 24:21, 19:17
// - Over eight phases use override 31:28, 27:25
// - Integral base 3:0, max 7:4, 2^(-s-1)
// - DCM steps gain per 16-clock units
// - Long DCM settles gain at bits 11:8
// - D mantissa is bits 5:2 over eight
// - D exponent shift plus one plus P
// - One phase uses D override 11:8, 7:6
// - D filter length from bit 12
// - Bits 15:8 set current high-pass coefficient
// - Bits 7:0 set low-droop feedback gain
`timescale 1ns/100ps
module lcg_comp_cfg
	import lcg_pkg::*;
#(
	parameter int NUM_RAILS = 2,
	parameter int PHW       = 5,
	parameter int RW        = (NUM_RAILS > 1) ? $clog2(NUM_RAILS) : 1
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire lcg_req_t             req,
	output logic [31:0]               reg_rdata,
	output logic                      reg_rvalid,
	output logic                      reg_err,
	input  wire logic [RW-1:0]        loop_rail,
	input  wire logic [PHW-1:0]       phase_cnt,
	input  wire logic [NUM_RAILS-1:0] dcm_mode,
	input  wire logic [NUM_RAILS-1:0] integ_moving,
	output logic [3:0]                p_mant,
	output logic signed [3:0]         p_exp,
	output logic                      p_zero,
	output logic                      p_fir,
	output logic [3:0]                d_mant,
	output logic [3:0]                d_exp,
	output logic                      d_fir,
	output logic [3:0]                i_shift,
	output logic                      i_settled,
	output logic [7:0]                cfb_hpf,
	output logic [7:0]                cfb_gain
);

	logic [31:0] prop_mem  [NUM_RAILS];
	logic [31:0] integ_mem [NUM_RAILS];
	logic [15:0] diff_mem  [NUM_RAILS];
	logic [15:0] cfb_mem   [NUM_RAILS];
	logic [3:0]  ishift_w  [NUM_RAILS];
	logic [NUM_RAILS-1:0] isettle_w;

	logic        page_ok;
	logic [RW-1:0] pg;
	logic        wr_hit;
	logic [31:0] prop_sel;
	logic [15:0] diff_sel;
	lcg_gain_t   p_com;
	lcg_gain_t   p_o1;
	lcg_gain_t   p_o2;
	lcg_gain_t   p_o8;
	lcg_gain_t   p_pick;
	lcg_gain_t   d_com;
	lcg_gain_t   d_o1;
	lcg_gain_t   d_pick;
	lcg_gain_t   none;
	logic [3:0]  d_exp_next;
	logic signed [3:0] p_exp_next;

	////////////////////////////////////////////////////////////////////
	// Access decode: page must name an existing rail
	assign page_ok = (req.page < 8'(NUM_RAILS));
	assign pg      = req.page[RW-1:0];
	assign wr_hit  = req.wr && page_ok && lcg_mapped(req.cmd);

	// Paged register storage, one copy per rail
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int r = 0; r < NUM_RAILS; r++) begin
				prop_mem[r]  <= LCG_RST_PROP;
				integ_mem[r] <= LCG_RST_INTEG;
				diff_mem[r]  <= LCG_RST_DIFF;
				cfb_mem[r]   <= LCG_RST_CFB;
			end
		end else if (wr_hit) begin
			unique case (req.cmd)
				LCG_CMD_PROP: begin
					prop_mem[pg] <= req.wdata;
				end
				LCG_CMD_INTEG: begin
					integ_mem[pg] <= req.wdata;
				end
				LCG_CMD_DIFF: begin
					diff_mem[pg] <= req.wdata[15:0] & LCG_DIFF_WMASK;
				end
				LCG_CMD_CFB: begin
					cfb_mem[pg] <= req.wdata[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data, one cycle after the request
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (req.rd && page_ok) begin
			unique case (req.cmd)
				LCG_CMD_PROP:  reg_rdata <= prop_mem[pg];
				LCG_CMD_INTEG: reg_rdata <= integ_mem[pg];
				LCG_CMD_DIFF:  reg_rdata <= {16'h0000, diff_mem[pg]};
				LCG_CMD_CFB:   reg_rdata <= {16'h0000, cfb_mem[pg]};
				default:       reg_rdata <= 32'h00000000;
			endcase
		end else if (req.rd) begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Read strobe and error flag, both one-cycle pulses
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid <= 1'b0;
			reg_err    <= 1'b0;
		end else begin
			reg_rvalid <= req.rd;
			reg_err    <= (req.rd || req.wr) &&
				!(page_ok && lcg_mapped(req.cmd));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Field extraction for the rail that the loop serves
	assign prop_sel = prop_mem[loop_rail];
	assign diff_sel = diff_mem[loop_rail];
	assign none     = '0;

	assign p_com = '{mant: prop_sel[LCG_P_COM_M +: 4],
		expo: prop_sel[LCG_P_COM_E +: 3]};
	assign p_o1 = '{mant: prop_sel[LCG_P_O1_M +: 4],
		expo: prop_sel[LCG_P_O1_E +: 3]};
	assign p_o2 = '{mant: prop_sel[LCG_P_O2_M +: 4],
		expo: prop_sel[LCG_P_O2_E +: 3]};
	assign p_o8 = '{mant: prop_sel[LCG_P_O8_M +: 4],
		expo: prop_sel[LCG_P_O8_E +: 3]};
	assign d_com = '{mant: diff_sel[LCG_D_MANT +: 4],
		expo: {1'b0, diff_sel[LCG_D_EXP +: 2]}};
	assign d_o1 = '{mant: diff_sel[LCG_D_O1_M +: 4],
		expo: {1'b0, diff_sel[LCG_D_O1_E +: 2]}};

	// Proportional gain selection by phase count
	lcg_gain_pick #(
		.PHW (PHW)
	) u_p_pick (
		.phases (phase_cnt),
		.com    (p_com),
		.ovr1   (p_o1),
		.ovr2   (p_o2),
		.ovr8   (p_o8),
		.sel    (p_pick)
	);

	// Derivative gain selection, single-phase override only
	lcg_gain_pick #(
		.PHW (PHW)
	) u_d_pick (
		.phases (phase_cnt),
		.com    (d_com),
		.ovr1   (d_o1),
		.ovr2   (none),
		.ovr8   (none),
		.sel    (d_pick)
	);

	// Exponents: P is biased by three, D adds one and the P shift
	assign p_exp_next = $signed({1'b0, p_pick.expo}) - LCG_P_EXP_BIAS;
	assign d_exp_next = 4'(d_pick.expo) + 4'h1 + 4'(p_pick.expo);

	// Registered gain outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			p_mant <= 4'h0;
			p_exp  <= 4'sh0;
			p_zero <= 1'b1;
			d_mant <= 4'h0;
			d_exp  <= 4'h0;
		end else begin
			p_mant <= p_pick.mant;
			p_exp  <= p_exp_next;
			p_zero <= (p_pick.mant == 4'h0);
			d_mant <= d_pick.mant;
			d_exp  <= d_exp_next;
		end
	end

	// Filter lengths and current feedback settings
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			p_fir    <= 1'b0;
			d_fir    <= 1'b0;
			cfb_hpf  <= 8'h00;
			cfb_gain <= 8'h00;
		end else begin
			p_fir    <= prop_sel[LCG_P_FIR];
			d_fir    <= diff_sel[LCG_D_FIR];
			cfb_hpf  <= cfb_mem[loop_rail][LCG_C_HPF +: 8];
			cfb_gain <= cfb_mem[loop_rail][LCG_C_GAIN +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Integral gain stepper, one per rail
	genvar gr;
	generate
		for (gr = 0; gr < NUM_RAILS; gr++) begin : g_integ
			lcg_integ_step u_step (
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.cfg       (integ_mem[gr][15:0]),
				.dcm       (dcm_mode[gr]),
				.moving    (integ_moving[gr]),
				.shift_reg (ishift_w[gr]),
				.settled   (isettle_w[gr])
			);
		end
	endgenerate

	// Integral outputs of the served rail
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			i_shift   <= 4'h0;
			i_settled <= 1'b0;
		end else begin
			i_shift   <= ishift_w[loop_rail];
			i_settled <= isettle_w[loop_rail];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	// A read is answered in the next cycle
	chk_rd_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req.rd |=> reg_rvalid ##1 !reg_rvalid || $past(req.rd))
		else $error("read strobe missing after request");

	// Write then read of the same page returns the data
	chk_page_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(req.wr && req.cmd == LCG_CMD_CFB && page_ok) ##1 !req.wr ##1
		(req.rd && req.cmd == LCG_CMD_CFB && req.page == $past(req.page, 2)
		&& !req.wr)
		|=> reg_rdata[15:0] == $past(req.wdata[15:0], 3))
		else $error("paged register readback mismatch");

	// Common P mantissa at three active phases
	chk_p_common: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && phase_cnt == PHW'(3)) |=>
		p_mant == $past(prop_sel[7:4]))
		else $error("common proportional mantissa not used");

	// P exponent is the field less three
	chk_p_bias: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && phase_cnt == PHW'(3)) |=>
		p_exp == $signed({1'b0, $past(prop_sel[2:0])}) - 4'sd3)
		else $error("proportional exponent bias wrong");

	// Single-phase override taken when live
	chk_p_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(phase_cnt == PHW'(1) && prop_sel[16:13] != 4'h0) |=>
		p_mant == $past(prop_sel[16:13]))
		else $error("one-phase proportional override ignored");

	// Two-phase override, or fallback when both fields are zero
	chk_p_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(phase_cnt == PHW'(2)) |=> p_mant == ($past(prop_sel[24:17]
		& 8'hf7) != 8'h00 ? $past(prop_sel[24:21])
		: $past(prop_sel[7:4])))
		else $error("two-phase proportional selection wrong");

	// Many-phase override
	chk_p_many: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(phase_cnt > PHW'(8) && prop_sel[31:28] != 4'h0) |=>
		p_mant == $past(prop_sel[31:28]))
		else $error("many-phase proportional override ignored");

	// D exponent sums its field, one and the P field
	chk_d_exp: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && phase_cnt == PHW'(3)) |=>
		d_exp == 4'($past(diff_sel[1:0]))
		+ 4'h1 + 4'($past(prop_sel[2:0])))
		else $error("derivative exponent sum wrong");

	// D mantissa and single-phase override
	chk_d_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(phase_cnt == PHW'(1)) |=> d_mant == ($past(diff_sel[11:6])
		!= 6'h00 ? $past(diff_sel[11:8])
		: $past(diff_sel[5:2])))
		else $error("derivative mantissa selection wrong");

	// Current feedback fields follow the served rail
	chk_cfb_fields: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		rst_n |=> {cfb_hpf, cfb_gain} == $past(cfb_mem[loop_rail])
		&& d_fir == $past(diff_sel[12]))
		else $error("feedback coefficients or filter bit wrong");

	// A write to a missing rail is refused with an error pulse
	chk_refused_err: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(req.wr && !page_ok) |=> reg_err)
		else $error("refused write raised no error");

	// A refused write leaves the rail 0 P and CFB copies alone
	chk_refused_keep: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(req.wr && !page_ok) |=>
		$stable(cfb_mem[0]) && $stable(prop_mem[0]))
		else $error("refused write changed a register");

	// Reserved derivative bits read back as zero
	chk_diff_upper_zero: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(req.rd && req.cmd == LCG_CMD_DIFF && page_ok) |=>
		reg_rdata[31:13] == 19'h00000)
		else $error("reserved derivative bits not zero");

	// A zero common mantissa gives a zero P gain
	chk_p_zero_gain: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && phase_cnt == PHW'(3) && prop_sel[7:4] == 4'h0)
		|=> p_zero)
		else $error("zero proportional gain not flagged");

	// Many phases with a dead override fall back to the common pair
	chk_p_many_fallback: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(phase_cnt > PHW'(8) && prop_sel[31:25] == 7'h00) |=>
		p_mant == $past(prop_sel[7:4]))
		else $error("many-phase fallback to common gain missing");

	// A write alone never raises the read strobe
	chk_write_no_rvalid: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(req.wr && !req.rd) |=> !reg_rvalid)
		else $error("read strobe after a write");

	// Integral outputs follow the rail that the loop serves
	chk_i_served_rail: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		rst_n |=> i_shift == $past(ishift_w[loop_rail])
		&& i_settled == $past(isettle_w[loop_rail]))
		else $error("integral outputs not from the served rail");

endmodule

// File: sim/lcg_host.sv
// Management bus host model issuing one paged register access per call.
// Assumes the block samples req on rising clk_sys edges.
`timescale 1ns/100ps
module lcg_host
	import lcg_pkg::*;
(
	input  wire logic        clk_sys,
	output lcg_req_t         req,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid,
	input  wire logic        reg_err
);
	logic d_used [0:255];

	////////////////////////////////////////////////////////////////////////
	// Idle bus, no derivative term in use on any rail
	initial begin
		req = '0;
		foreach (d_used[i]) d_used[i] = 1'b0;
	end

	// Write one register; sent is what really went on the bus
	task automatic write(input logic [7:0] cmd, input logic [7:0] page,
		input logic [31:0] data, output logic [31:0] sent,
		output logic err);
		sent = data;
		if (cmd == LCG_CMD_PROP && d_used[page]) begin
			sent[LCG_P_FIR] = 1'b1;
		end
		if (cmd == LCG_CMD_DIFF) begin
			d_used[page] = data[5:2] != 4'h0;
		end
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, cmd: cmd, page: page, wdata: sent};
		@(posedge clk_sys);
		req.wr    <= 1'b0;
		req.wdata <= ~sent; // Released data never repeats the last word
		#1;
		err = reg_err;
	endtask

	// Read one register, answer sampled in the cycle it stands
	task automatic read(input logic [7:0] cmd, input logic [7:0] page,
		output logic [31:0] data, output logic ok, output logic err);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, cmd: cmd, page: page, wdata: req.wdata};
		@(posedge clk_sys);
		req.rd    <= 1'b0;
		req.wdata <= ~req.wdata;
		#1;
		data = reg_rdata;
		ok   = reg_rvalid;
		err  = reg_err;
	endtask
endmodule

// File: sim/lcg_comp_cfg_bench.sv
// Self-checking bench for the paged compensation gain registers.
// Assumes two rails, five-bit phase count and the host model beside it.
`timescale 1ns/100ps
module lcg_comp_cfg_bench;
	import lcg_pkg::*;

`define LCG_CHK(what, expv, got) \
	begin \
		checks_done++; \
		if ((got) !== (expv)) begin \
			miscompares++; \
			$display("CHECK FAILED %s expected %h seen %h", what, expv, got); \
		end \
	end

	logic              clk_sys, rst_n;
	lcg_req_t          req;
	logic [31:0]       reg_rdata;
	logic              reg_rvalid, reg_err, loop_rail, p_zero, p_fir;
	logic [4:0]        phase_cnt;
	logic [1:0]        dcm_mode, integ_moving;
	logic [3:0]        p_mant, d_mant, d_exp, i_shift;
	logic signed [3:0] p_exp;
	logic              d_fir, i_settled;
	logic [7:0]        cfb_hpf, cfb_gain;
	int                seed = 32'h6c23;
	int                miscompares = 0;
	int                checks_done = 0;
	logic [31:0]       pr [2];
	logic [15:0]       dr [2], cr [2];

	lcg_comp_cfg #(.NUM_RAILS(2), .PHW(5)) lcg_comp_cfg_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
		.loop_rail(loop_rail), .phase_cnt(phase_cnt), .dcm_mode(dcm_mode),
		.integ_moving(integ_moving), .p_mant(p_mant), .p_exp(p_exp),
		.p_zero(p_zero), .p_fir(p_fir), .d_mant(d_mant), .d_exp(d_exp),
		.d_fir(d_fir), .i_shift(i_shift), .i_settled(i_settled),
		.cfb_hpf(cfb_hpf), .cfb_gain(cfb_gain));

	lcg_host lcg_host_inst (.clk_sys(clk_sys), .req(req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err));

	////////////////////////////////////////////////////////////////////////
	// Clock, and a watchdog sized well above the planned run
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#(100 * 20000);
		miscompares++;
		give_verdict();
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Stored image of a write: upper derivative bits and high halves drop
	function automatic logic [31:0] keep(logic [7:0] c, logic [31:0] d);
		if (c == LCG_CMD_DIFF) return d & {16'h0, LCG_DIFF_WMASK};
		if (c == LCG_CMD_CFB) return d & 32'h0000ffff;
		return d;
	endfunction

	// Active P pair: override only when its pair is not all zero
	function automatic lcg_gain_t pick(logic [31:0] p, logic [4:0] ph);
		if (ph == 5'd1 && {p[16:13], p[11:9]} != 7'h0)
			return {p[16:13], p[11:9]};
		if (ph == 5'd2 && {p[24:21], p[19:17]} != 7'h0)
			return {p[24:21], p[19:17]};
		if (ph > 5'd8 && p[31:25] != 7'h0) return {p[31:28], p[27:25]};
		return {p[7:4], p[2:0]};
	endfunction

	task automatic wr(input logic [7:0] c, input logic [7:0] p,
		input logic [31:0] d, output logic [31:0] s);
		logic e;
		lcg_host_inst.write(c, p, d, s, e);
		`LCG_CHK("write err", 1'b0, e)
		if (c == LCG_CMD_PROP) pr[p[0]] = s;
		if (c == LCG_CMD_DIFF) dr[p[0]] = keep(c, s);
		if (c == LCG_CMD_CFB) cr[p[0]] = s[15:0];
	endtask

	task automatic rd_chk(input logic [7:0] c, input logic [7:0] p,
		input logic [31:0] x);
		logic [31:0] d;
		logic        v, e;
		lcg_host_inst.read(c, p, d, v, e);
		`LCG_CHK("read valid", 1'b1, v)
		`LCG_CHK("read data", x, d)
	endtask

	// Compare the P, D and current feedback outputs with the settings of one rail
	task automatic gain_chk(input logic [31:0] p, input logic [15:0] d,
		input logic [15:0] cf, input logic [4:0] ph);
		lcg_gain_t g, dg;
		g  = pick(p, ph);
		dg = (ph == 5'd1 && d[11:6] != 6'h0) ?
			{d[11:8], 1'b0, d[7:6]} : {d[5:2], 1'b0, d[1:0]};
		`LCG_CHK("p_mant", g.mant, p_mant)
		`LCG_CHK("p_exp", $signed({1'b0, g.expo}) - 4'sd3, p_exp)
		`LCG_CHK("p_zero", g.mant == 4'h0, p_zero)
		`LCG_CHK("p_fir", p[8], p_fir)
		`LCG_CHK("d_mant", dg.mant, d_mant)
		`LCG_CHK("d_exp", {2'b0, dg.expo[1:0]} + 4'd1 + {1'b0, g.expo},
			d_exp)
		`LCG_CHK("d_fir", d[12], d_fir)
		`LCG_CHK("cfb_hpf", cf[15:8], cfb_hpf)
		`LCG_CHK("cfb_gain", cf[7:0], cfb_gain)
	endtask

	// Cycles until the integral shift next moves
	task automatic wait_change(output int n);
		logic [3:0] last;
		#1;
		last = i_shift;
		n = 0;
		while (i_shift === last && n < 300) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r, s, d;
		logic        v, e;
		logic [7:0]  cmds [4];
		logic [4:0]  phs [7];
		logic [15:0] dcs [2];
		int          n1, n2;
		cmds = '{LCG_CMD_PROP, LCG_CMD_INTEG, LCG_CMD_DIFF, LCG_CMD_CFB};
		phs = '{5'd1, 5'd2, 5'd3, 5'd8, 5'd9, 5'd31, 5'd0};
		dcs = '{16'h1509, 16'h0c03};
		pr = '{LCG_RST_PROP, LCG_RST_PROP};
		dr = '{LCG_RST_DIFF, LCG_RST_DIFF};
		cr = '{LCG_RST_CFB, LCG_RST_CFB};
		rst_n = 1'b0;
		loop_rail = 1'b0;
		phase_cnt = 5'd3;
		dcm_mode = 2'b00;
		integ_moving = 2'b00;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		gain_chk(pr[0], dr[0], cr[0], 5'd3);
		for (int p = 0; p < 2; p++) begin
			rd_chk(LCG_CMD_PROP, p[7:0], LCG_RST_PROP);
			rd_chk(LCG_CMD_INTEG, p[7:0], LCG_RST_INTEG);
			rd_chk(LCG_CMD_DIFF, p[7:0], {16'h0, LCG_RST_DIFF});
			rd_chk(LCG_CMD_CFB, p[7:0], {16'h0, LCG_RST_CFB});
		end
		// Refused accesses: unmapped code and missing rail
		lcg_host_inst.read(8'hdc, 8'h00, d, v, e);
		`LCG_CHK("unmapped err", 1'b1, e)
		`LCG_CHK("unmapped data", 32'h0, d)
		lcg_host_inst.write(LCG_CMD_CFB, 8'h02, 32'h1234, s, e);
		`LCG_CHK("bad page err", 1'b1, e)
		rd_chk(LCG_CMD_CFB, 8'h00, {16'h0, LCG_RST_CFB});
		rd_chk(LCG_CMD_CFB, 8'h01, {16'h0, LCG_RST_CFB});
		$display("test registers done");
		// Random write and read back on random rails
		for (int n = 0; n < 24; n++) begin
			r = $random(seed);
			d = $random(seed);
			wr(cmds[r[1:0]], {7'h0, r[2]}, d, s);
			rd_chk(cmds[r[1:0]], {7'h0, r[2]}, keep(cmds[r[1:0]], s));
		end
		$display("test readback done");
		// Random gains; even passes clear every P override pair
		for (int n = 0; n < 42; n++) begin
			r = $random(seed);
			d = $random(seed);
			if (n % 2 == 0) d[31:9] = 23'h0;
			wr(LCG_CMD_DIFF, {7'h0, r[0]}, {16'h0, d[15:0]}, s);
			wr(LCG_CMD_PROP, {7'h0, r[0]}, d, s);
			wr(LCG_CMD_CFB, {7'h0, r[0]}, $random(seed), s);
			@(posedge clk_sys);
			loop_rail <= r[1];
			phase_cnt <= phs[n % 7];
			repeat (2) @(posedge clk_sys);
			#1;
			gain_chk(pr[r[1]], dr[r[1]], cr[r[1]], phs[n % 7]);
		end
		$display("test gains done");
		// Continuous conduction: base or maximum shift
		for (int n = 0; n < 8; n++) begin
			r = $random(seed);
			wr(LCG_CMD_INTEG, {7'h0, r[0]}, {16'h0, r[31:16]}, s);
			@(posedge clk_sys);
			loop_rail <= r[0];
			integ_moving <= r[3:2];
			repeat (3) @(posedge clk_sys);
			#1;
			`LCG_CHK("i_shift", r[2 + r[0]] ? r[23:20] : r[19:16], i_shift)
		end
		$display("test integral done");
		// Discontinuous conduction: step spacing and settling, both ways
		integ_moving <= 2'b00;
		for (int k = 0; k < 2; k++) begin
			wr(LCG_CMD_INTEG, 8'h00, {16'h0, dcs[k]}, s);
			@(posedge clk_sys);
			loop_rail <= 1'b0;
			repeat (3) @(posedge clk_sys);
			dcm_mode <= 2'b01;
			wait_change(n1);
			wait_change(n2);
			`LCG_CHK("step gap", dcs[k][15:12] == 4'h0 ? 1 :
				dcs[k][15:12] * LCG_STEP_CLKS, n2)
			n1 = 0;
			while (i_settled !== 1'b1 && n1 < 300) begin
				@(posedge clk_sys);
				#1;
				n1++;
			end
			`LCG_CHK("i_settled", 1'b1, i_settled)
			`LCG_CHK("dcm shift", dcs[k][11:8], i_shift)
			@(posedge clk_sys);
			dcm_mode <= 2'b00;
			repeat (3) @(posedge clk_sys);
			#1;
			`LCG_CHK("ccm shift", dcs[k][3:0], i_shift)
		end
		$display("test dcm done");
		give_verdict();
	end
endmodule
